// File: design/hci_pkg.sv
// package of constants for the hub connect and interrupt logic
package hci_pkg;
  // register offsets on the serial slave port
  localparam logic [7:0] HCI_EVENT_FLAG_ADDR = 8'hE8;
  localparam logic [7:0] HCI_EVENT_ENABLE_ADDR = 8'hE9;
  localparam logic [7:0] HCI_INTERLOCK_ADDR = 8'hE7;
  localparam logic [7:0] HCI_CONFIG_ADDR = 8'hE6;
  // reset values
  localparam logic [7:0] HCI_EVENT_FLAG_RST = 8'h00;
  localparam logic [7:0] HCI_EVENT_ENABLE_RST = 8'h00;
  localparam logic [7:0] HCI_INTERLOCK_RST = 8'h01;
  localparam logic [7:0] HCI_CONFIG_RST = 8'h00;
  // field positions
  localparam int HCI_CONNECT_HOLD_BIT = 0;
  localparam int HCI_SUSP_LEVEL_BIT = 0;
  localparam int HCI_NUM_EVENTS = 8;
  // reference clock select codes
  localparam logic [1:0] HCI_REF_38M4 = 2'h0;
  localparam logic [1:0] HCI_REF_26M0 = 2'h1;
  localparam logic [1:0] HCI_REF_19M2 = 2'h2;
  localparam logic [1:0] HCI_REF_12M0 = 2'h3;
  // reference rate in kHz per select code
  localparam logic [15:0] HCI_KHZ_38M4 = 16'h9600;
  localparam logic [15:0] HCI_KHZ_26M0 = 16'h6590;
  localparam logic [15:0] HCI_KHZ_19M2 = 16'h4B00;
  localparam logic [15:0] HCI_KHZ_12M0 = 16'h2EE0;
  // hub stage encoding
  typedef enum logic [1:0]
  {
    HCI_ST_INIT = 2'b00,
    HCI_ST_CONFIG = 2'b01,
    HCI_ST_COMM = 2'b10
  } hci_stage_t;
endpackage : hci_pkg

// File: design/hci_event_if.sv
// interface carrying event conditions and flag clears to the latch
`timescale 1ns/10ps
`default_nettype none
interface hci_event_if;
  import hci_pkg::*;
  logic [HCI_NUM_EVENTS-1:0] cond;
  logic [HCI_NUM_EVENTS-1:0] clear;
  logic [HCI_NUM_EVENTS-1:0] flags;
  modport ctrl (output cond, output clear, input flags);
  modport latch (input cond, input clear, output flags);
endinterface : hci_event_if
`default_nettype wire

// File: design/hci_event_latch.sv
// per-bit edge-triggered sticky event flags
`timescale 1ns/10ps
`default_nettype none
module hci_event_latch
  import hci_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // event bundle
  hci_event_if.latch ev
);
  logic [HCI_NUM_EVENTS-1:0] cond_q;
  logic [HCI_NUM_EVENTS-1:0] flag_q;
  logic [HCI_NUM_EVENTS-1:0] next_cond_q;
  logic [HCI_NUM_EVENTS-1:0] next_flag_q;

  // a new rising condition sets; a set beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < HCI_NUM_EVENTS; gi++)
    begin : g_bit
      always_comb
      begin
        next_cond_q[gi] = ev.cond[gi];
        // a condition that stays high after a clear does not re-raise
        if (ev.cond[gi] && !cond_q[gi])
          next_flag_q[gi] = 1'b1; // R12
        else if (ev.clear[gi])
          next_flag_q[gi] = 1'b0; // R10
        else
          next_flag_q[gi] = flag_q[gi]; // R11
      end
    end
  endgenerate

  // register the flags
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cond_q <= HCI_EVENT_FLAG_RST;
      flag_q <= HCI_EVENT_FLAG_RST; // R21
    end
    else if (clk_en_in)
    begin
      cond_q <= next_cond_q;
      flag_q <= next_flag_q;
    end
  end

  assign ev.flags = flag_q;

  a_flag_sticky: assert property (@(posedge mclk_in) disable iff (reset_in)
    (clk_en_in && flag_q[0] && !ev.clear[0]) |=> flag_q[0]) // R11
    else $error("event flag dropped without clear");
  a_flag_no_rerise: assert property (@(posedge mclk_in) disable iff (reset_in)
    (clk_en_in && cond_q[0] && ev.cond[0] && ev.clear[0]) |=> !flag_q[0]) // R12
    else $error("persisting condition re-raised flag");
endmodule : hci_event_latch
`default_nettype wire

// File: design/hci_hub_ctrl.sv
// hub connect staging, reference select capture and interrupt pin logic
//
// Summary of operation
// R1: connect pin high moves hub to communication
// R2: pin low: wait for software hold clear
// R3: pin tied high ignores hold bit
// R4: rising connect pin enters communication stage
// R5: host keeps connect low during standby
// R6: logic clocked on rising reference edge only
// R7: select codes 38.4, 26.0, 19.2, 12.0 MHz
// R8: event flags readable at E8h
// R9: enable register at E9h gates interrupt
// R10: flags stay set until software clears
// R11: flags survive condition going inactive
// R12: flags set only on new occurrence
// R13: option bit turns pin into level indication
// R14: level mode: low when suspended or unconfigured
// R15: level mode: high when configured, not suspended
// R16: port selective suspend ignored in level mode
// R17: level mode tracks status without software
// R18: interrupt pin is open drain
// R19: event mode: low while enabled flag set
// R20: select pins captured once during init
// R21: reset restores all registers to defaults
`timescale 1ns/10ps
`default_nettype none
module hci_hub_ctrl
  import hci_pkg::*;
(
  // clock, enable and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // pins from the board
  input wire logic hub_connect_in,
  input wire logic [1:0] ref_sel_in,
  // serial slave register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // hub status from the core
  input wire logic [7:0] event_cond_in,
  input wire logic hub_suspended_in,
  input wire logic hub_configured_in,
  input wire logic port_suspend_in,
  // interrupt pin, open drain
  input wire logic int_pin_in,
  output logic int_pin_out,
  output logic int_pin_oe_out,
  // stage and reference outputs
  output logic comm_stage_out,
  output logic [1:0] ref_sel_out,
  output logic [15:0] ref_khz_out
);
  hci_event_if ev ();

  // pin synchronisers
  logic [1:0] conn_sync;
  logic [1:0] next_conn_sync;
  logic [1:0] sel_s1;
  logic [1:0] sel_s2;
  logic [1:0] next_sel_s1;
  logic [1:0] next_sel_s2;
  logic susp_s1;
  logic susp_s2;
  logic cfg_s1;
  logic cfg_s2;
  logic next_susp_s1;
  logic next_susp_s2;
  logic next_cfg_s1;
  logic next_cfg_s2;
  logic conn_prev;
  logic next_conn_prev;
  logic pin_s1;
  logic pin_s2;
  logic next_pin_s1;
  logic next_pin_s2;

  // registers
  logic [7:0] enable_reg;
  logic [7:0] next_enable_reg;
  logic [7:0] interlock_reg;
  logic [7:0] next_interlock_reg;
  logic [7:0] config_reg;
  logic [7:0] next_config_reg;
  logic [7:0] clear_q;
  logic [7:0] next_clear_q;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  // stage machine and captured select
  hci_stage_t stage;
  hci_stage_t next_stage;
  logic [1:0] ref_cap;
  logic [1:0] next_ref_cap;
  logic [1:0] init_cnt;
  logic [1:0] next_init_cnt;
  logic [15:0] khz;
  logic [15:0] next_khz;
  logic comm;
  logic next_comm;

  // interrupt drive
  logic int_low;
  logic next_int_low;
  logic any_event;

  assign ev.cond = event_cond_in;
  assign ev.clear = clear_q;

  // sticky flag latch
  hci_event_latch u_latch
  (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .ev(ev)
  );

  // two-stage synchronisers for the asynchronous pins
  always_comb
  begin
    next_conn_sync = {conn_sync[0], hub_connect_in};
    next_sel_s1 = ref_sel_in;
    next_sel_s2 = sel_s1;
    next_susp_s1 = hub_suspended_in;
    next_susp_s2 = susp_s1;
    next_cfg_s1 = hub_configured_in;
    next_cfg_s2 = cfg_s1;
    next_pin_s1 = int_pin_in;
    next_pin_s2 = pin_s1;
    next_conn_prev = conn_sync[1];
  end

  always_ff @(posedge mclk_in or posedge reset_in) // R6
  begin
    if (reset_in)
    begin
      conn_sync <= 2'h0;
      sel_s1 <= 2'h0;
      sel_s2 <= 2'h0;
      susp_s1 <= 1'b0;
      susp_s2 <= 1'b0;
      cfg_s1 <= 1'b0;
      cfg_s2 <= 1'b0;
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      conn_prev <= 1'b0;
    end
    else if (clk_en_in)
    begin
      conn_sync <= next_conn_sync;
      sel_s1 <= next_sel_s1;
      sel_s2 <= next_sel_s2;
      susp_s1 <= next_susp_s1;
      susp_s2 <= next_susp_s2;
      cfg_s1 <= next_cfg_s1;
      cfg_s2 <= next_cfg_s2;
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
      conn_prev <= next_conn_prev;
    end
  end

  // register writes and reads; the flag register clears by writing ones
  always_comb
  begin
    next_enable_reg = enable_reg;
    next_interlock_reg = interlock_reg;
    next_config_reg = config_reg;
    next_clear_q = 8'h00;
    next_rdata = rdata;
    next_rvalid = reg_rd_in;
    if (reg_wr_in)
    begin
      if (reg_addr_in == HCI_EVENT_FLAG_ADDR)
        next_clear_q = reg_wdata_in; // R10
      else if (reg_addr_in == HCI_EVENT_ENABLE_ADDR)
        next_enable_reg = reg_wdata_in; // R9
      else if (reg_addr_in == HCI_INTERLOCK_ADDR)
        next_interlock_reg = reg_wdata_in & 8'h01;
      else if (reg_addr_in == HCI_CONFIG_ADDR)
        next_config_reg = reg_wdata_in & 8'h01;
    end
    if (reg_rd_in)
    begin
      if (reg_addr_in == HCI_EVENT_FLAG_ADDR)
        next_rdata = ev.flags; // R8
      else if (reg_addr_in == HCI_EVENT_ENABLE_ADDR)
        next_rdata = enable_reg;
      else if (reg_addr_in == HCI_INTERLOCK_ADDR)
        next_rdata = interlock_reg;
      else if (reg_addr_in == HCI_CONFIG_ADDR)
        next_rdata = config_reg;
      else
        next_rdata = 8'h00; // unmapped reads as zero
    end
  end

  // register state
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      enable_reg <= HCI_EVENT_ENABLE_RST; // R21
      interlock_reg <= HCI_INTERLOCK_RST;
      config_reg <= HCI_CONFIG_RST;
      clear_q <= 8'h00;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else if (clk_en_in)
    begin
      enable_reg <= next_enable_reg;
      interlock_reg <= next_interlock_reg;
      config_reg <= next_config_reg;
      clear_q <= next_clear_q;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // stage machine: init captures select, config waits for connect or a cleared hold bit
  always_comb
  begin
    next_stage = stage;
    next_init_cnt = init_cnt;
    next_ref_cap = ref_cap;
    next_khz = khz;
    next_comm = comm;
    case (stage)
      HCI_ST_INIT:
      begin
        // wait until both synchroniser stages hold the pin value, else reset zeros get captured
        next_init_cnt = init_cnt + 2'h1;
        if (init_cnt == 2'h2)
        begin
          // select pins are sampled once here and held afterwards
          next_ref_cap = sel_s2; // R20
          case (sel_s2) // R7
            HCI_REF_38M4: next_khz = HCI_KHZ_38M4;
            HCI_REF_26M0: next_khz = HCI_KHZ_26M0;
            HCI_REF_19M2: next_khz = HCI_KHZ_19M2;
            default: next_khz = HCI_KHZ_12M0;
          endcase
          next_stage = HCI_ST_CONFIG;
        end
      end
      HCI_ST_CONFIG:
      begin
        // a high pin, tied or newly risen, wins over the hold bit
        if (conn_sync[1]) // R1 R3
        begin
          next_stage = HCI_ST_COMM;
          next_comm = 1'b1;
        end
        else if (conn_sync[1] && !conn_prev) // R4
        begin
          next_stage = HCI_ST_COMM;
          next_comm = 1'b1;
        end
        else if (!interlock_reg[HCI_CONNECT_HOLD_BIT]) // R2
        begin
          next_stage = HCI_ST_COMM;
          next_comm = 1'b1;
        end
      end
      HCI_ST_COMM:
      begin
        next_comm = 1'b1;
      end
      default:
      begin
        next_stage = HCI_ST_INIT;
        next_comm = 1'b0;
      end
    endcase
  end

  // stage state
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      stage <= HCI_ST_INIT;
      init_cnt <= 2'h0;
      ref_cap <= HCI_REF_38M4;
      khz <= HCI_KHZ_38M4;
      comm <= 1'b0;
    end
    else if (clk_en_in)
    begin
      stage <= next_stage;
      init_cnt <= next_init_cnt;
      ref_cap <= next_ref_cap;
      khz <= next_khz;
      comm <= next_comm;
    end
  end

  // interrupt pin: level mode ignores port suspend and software
  assign any_event = |(ev.flags & enable_reg); // R9 R19
  always_comb
  begin
    if (config_reg[HCI_SUSP_LEVEL_BIT]) // R13
      next_int_low = susp_s2 || !cfg_s2; // R14 R15 R16 R17
    else
      next_int_low = any_event; // R19
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      int_low <= 1'b0;
    else if (clk_en_in)
      int_low <= next_int_low;
  end

  // open drain: drive zero only while asserted
  assign int_pin_out = 1'b0; // R18
  assign int_pin_oe_out = int_low; // R18
  assign reg_rdata_out = rdata;
  assign reg_rvalid_out = rvalid;
  assign comm_stage_out = comm;
  assign ref_sel_out = ref_cap;
  assign ref_khz_out = khz;

  sequence s_conn_high;
    conn_sync[1] && stage == HCI_ST_CONFIG && clk_en_in;
  endsequence
  a_connect_enter: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_conn_high |=> comm) // R1
    else $error("connect high did not enter communication");
  a_hold_blocks: assert property (@(posedge mclk_in) disable iff (reset_in)
    (stage == HCI_ST_CONFIG && !conn_sync[1] && interlock_reg[0] && clk_en_in)
    |=> !comm) // R2
    else $error("left config with hold set and pin low");
  a_comm_sticky: assert property (@(posedge mclk_in) disable iff (reset_in)
    comm |=> comm) // R3
    else $error("communication stage dropped");
  a_ref_held: assert property (@(posedge mclk_in) disable iff (reset_in)
    (stage == HCI_ST_COMM) |=> $stable(ref_cap)) // R20
    else $error("captured select changed after init");
  a_level_mode: assert property (@(posedge mclk_in) disable iff (reset_in)
    (clk_en_in && config_reg[0] && (susp_s2 || !cfg_s2)) |=> int_pin_oe_out) // R14
    else $error("level mode did not assert on suspend");
  a_level_release: assert property (@(posedge mclk_in) disable iff (reset_in)
    (clk_en_in && config_reg[0] && !susp_s2 && cfg_s2) |=> !int_pin_oe_out) // R15
    else $error("level mode did not release");
  a_event_mode: assert property (@(posedge mclk_in) disable iff (reset_in)
    (clk_en_in && !config_reg[0]) |=> (int_pin_oe_out == $past(any_event))) // R19
    else $error("event mode pin mismatch");
  a_od_drive: assert property (@(posedge mclk_in) disable iff (reset_in)
    int_pin_oe_out |-> !int_pin_out) // R18
    else $error("open drain drove high");
endmodule : hci_hub_ctrl
`default_nettype wire

// File: bench/hci_host_model.sv
// host model driving the serial slave register port of the hub logic
`timescale 1ns/10ps
`default_nettype none
module hci_host_model
(
  // clock
  input wire logic mclk_in,
  // register port towards the hub
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  // idle port from time zero so nothing is taken during reset
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // one write strobe; writing ones to the flag register clears flags
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
  endtask
  // one read; data taken with the valid pulse, bounded wait
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge mclk_in);
    reg_rd_out <= 1'b0;
    for (i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (reg_rvalid_in === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata_in;
      end
      else
        @(posedge mclk_in);
    end
  endtask
endmodule // hci_host_model
`default_nettype wire

// File: bench/tb_hub_connect_and_interrupt_logic.sv
// self-checking bench for the hub connect and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module tb_hub_connect_and_interrupt_logic;
  import hci_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic hub_connect_in = 1'b0;
  logic [1:0] ref_sel_in = 2'h0;
  logic [7:0] event_cond_in = 8'h00;
  logic hub_suspended_in = 1'b0;
  logic hub_configured_in = 1'b0;
  logic port_suspend_in = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, int_pin, int_oe, comm, int_line;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] sel_out;
  logic [15:0] khz_out;
  int mismatches = 0;
  int comparisons = 0;
  int flags_m, cond_m, en, c, w, i, seed;
  int khz_m [4] = '{38400, 26000, 19200, 12000};
  // 40 MHz reference clock
  always #12.5 mclk_in = ~mclk_in;
  // open-drain line with pull-up, read back by the pin input
  assign int_line = int_oe ? int_pin : 1'b1;
  hci_host_model u_host (.mclk_in(mclk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata),
    .reg_rvalid_in(reg_rvalid));
  hci_hub_ctrl u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .hub_connect_in(hub_connect_in), .ref_sel_in(ref_sel_in), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid), .event_cond_in(event_cond_in),
    .hub_suspended_in(hub_suspended_in), .hub_configured_in(hub_configured_in),
    .port_suspend_in(port_suspend_in), .int_pin_in(int_line), .int_pin_out(int_pin),
    .int_pin_oe_out(int_oe), .comm_stage_out(comm), .ref_sel_out(sel_out),
    .ref_khz_out(khz_out));
  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk({15'h0, ok}, 16'h1, "read answer");
    chk({8'h0, d}, {8'h0, exp}, msg);
  endtask
  // connect pin held low through reset; select pins set to the applied rate
  task automatic do_reset(input logic [1:0] sel);
    reset_in <= 1'b1;
    hub_connect_in <= 1'b0;
    ref_sel_in <= sel;
    event_cond_in <= 8'h00;
    flags_m = 0;
    cond_m = 0;
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    ref_sel_in <= ~sel;
  endtask
  // bounded wait for the communication stage
  task automatic wait_comm(input string msg);
    for (i = 0; i < 8 && comm !== 1'b1; i++)
      @(posedge mclk_in);
    #1;
    chk({15'h0, comm}, 16'h1, msg);
  endtask
  // conditions change at a clock edge; model keeps rising edges only
  task automatic set_cond(input int v);
    @(posedge mclk_in);
    event_cond_in <= v[7:0];
    flags_m = flags_m | (v & ~cond_m & 255);
    cond_m = v & 255;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic chk_flags(input string msg);
    repeat (3) @(posedge mclk_in);
    rchk(HCI_EVENT_FLAG_ADDR, flags_m[7:0], msg);
    chk({15'h0, int_line}, {15'h0, (flags_m & en) == 0}, "event line");
  endtask
  // run limit cuts a hang short
  initial
  begin
    #2000000;
    mismatches++;
    $display("unexpected at %0t: run limit reached", $time);
    end_of_test();
  end
  initial
  begin
    seed = $urandom(70);
    for (c = 0; c < 4; c++)
    begin
      do_reset(c[1:0]);
      repeat (4) @(posedge mclk_in);
      chk({14'h0, sel_out}, c[15:0], "captured select");
      chk(khz_out, khz_m[c][15:0], "rate decode");
    end
    rchk(HCI_EVENT_FLAG_ADDR, HCI_EVENT_FLAG_RST, "flag default");
    rchk(HCI_EVENT_ENABLE_ADDR, HCI_EVENT_ENABLE_RST, "enable default");
    rchk(HCI_INTERLOCK_ADDR, HCI_INTERLOCK_RST, "interlock default");
    rchk(HCI_CONFIG_ADDR, HCI_CONFIG_RST, "config default");
    rchk(8'h10, 8'h00, "unmapped read");
    repeat (20) @(posedge mclk_in);
    chk({15'h0, comm}, 16'h0, "held out of comm");
    u_host.wr(HCI_INTERLOCK_ADDR, 8'h00);
    wait_comm("hold released");
    $display("test reset and hold done");
    do_reset(2'($urandom_range(3)));
    repeat (10) @(posedge mclk_in);
    chk({15'h0, comm}, 16'h0, "low pin waits");
    hub_connect_in <= 1'b1;
    wait_comm("rising pin");
    rchk(HCI_INTERLOCK_ADDR, 8'h01, "hold still set");
    do_reset(2'($urandom_range(3)));
    hub_connect_in <= 1'b1;
    wait_comm("pin high ignores hold");
    $display("test connect done");
    // a write while the clock enable is low must leave the register untouched
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    u_host.wr(HCI_EVENT_ENABLE_ADDR, 8'hA5);
    @(posedge mclk_in);
    clk_en_in <= 1'b1;
    rchk(HCI_EVENT_ENABLE_ADDR, HCI_EVENT_ENABLE_RST, "frozen write ignored");
    $display("test clock enable done");
    for (w = 0; w < 6; w++)
    begin
      en = $urandom & 255;
      u_host.wr(HCI_EVENT_ENABLE_ADDR, en[7:0]);
      rchk(HCI_EVENT_ENABLE_ADDR, en[7:0], "enable readback");
      set_cond($urandom & 255);
      chk_flags("flags set");
      c = $urandom & 255;
      u_host.wr(HCI_EVENT_FLAG_ADDR, c[7:0]);
      flags_m = flags_m & ~c;
      chk_flags("cleared, condition held");
      set_cond(0);
      chk_flags("condition gone");
      port_suspend_in <= 1'($urandom_range(1));
    end
    $display("test events done");
    en = 255;
    u_host.wr(HCI_EVENT_ENABLE_ADDR, 8'hFF);
    set_cond(255);
    u_host.wr(HCI_CONFIG_ADDR, 8'h01);
    for (c = 0; c < 8; c++)
    begin
      @(posedge mclk_in);
      hub_suspended_in <= c[0];
      hub_configured_in <= c[1];
      port_suspend_in <= c[2];
      repeat (6) @(posedge mclk_in);
      chk({15'h0, int_line}, {15'h0, !(c[0] || !c[1])}, "level line");
    end
    u_host.wr(HCI_CONFIG_ADDR, 8'h00);
    chk_flags("back to event mode");
    $display("test level mode done");
    end_of_test();
  end
endmodule // tb_hub_connect_and_interrupt_logic
`default_nettype wire
